// ==== rtl/wwd_top.sv ====
/*
 * window watchdog with wake-up: supervises a microcontroller through
 * heartbeat_input and mode_input, drives an open-drain reset pin and
 * peripheral_permit_output. assumes all inputs are asynchronous pins
 * and that supply_ok_input comes from an analogue supply monitor.
 */
`timescale 1ns/100ps

// ==========================================

`include "wwd_defines.svh"

module wwd_top import wwd_pkg::*; #(
	parameter int unsigned POR_HOLD_CYC = `WWD_POR_HOLD_CYC,
	parameter int unsigned SWITCH_TMO_CYC = `WWD_SWITCH_TMO_CYC,
	parameter int unsigned SHORT_DIS_CYC = `WWD_SHORT_DIS_CYC,
	parameter int unsigned SHORT_EN_CYC = `WWD_SHORT_EN_CYC,
	parameter int unsigned LONG_DIS_CYC = `WWD_LONG_DIS_CYC,
	parameter int unsigned LONG_EN_CYC = `WWD_LONG_EN_CYC,
	parameter int unsigned TRG_LOW_MAX_CYC = `WWD_TRG_LOW_MAX_CYC,
	parameter int unsigned RST_PULSE_CYC = `WWD_RST_PULSE_CYC,
	parameter int unsigned DEBOUNCE_CYC = `WWD_DEBOUNCE_CYC,
	parameter int unsigned TIMER_W = `WWD_TIMER_W
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic heartbeat_input,
	input wire logic mode_input,
	input wire logic wakeup_input,
	input wire logic supply_ok_input,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	output logic peripheral_permit_output
);

	// ==========================================
	// elaboration checks
	localparam longint unsigned TMAX = (64'h1 << TIMER_W) - 64'h1;

	if (POR_HOLD_CYC < 1 || SWITCH_TMO_CYC < 1 || SHORT_DIS_CYC < 1 || SHORT_EN_CYC < 1 ||
		LONG_DIS_CYC < 1 || LONG_EN_CYC < 1 || RST_PULSE_CYC < 1) begin : g_bad_zero
		$error("wwd_top: every period needs at least one cycle");
	end
	if (POR_HOLD_CYC > TMAX || SWITCH_TMO_CYC > TMAX || LONG_DIS_CYC > TMAX ||
		LONG_EN_CYC > TMAX || TRG_LOW_MAX_CYC > TMAX || SHORT_DIS_CYC > TMAX ||
		SHORT_EN_CYC > TMAX || RST_PULSE_CYC > TMAX) begin : g_bad_width
		$error("wwd_top: a period does not fit TIMER_W");
	end
	if (TRG_LOW_MAX_CYC < 1) begin : g_bad_trg
		$error("wwd_top: TRG_LOW_MAX_CYC must be at least 1");
	end

	// ==========================================
	// declarations
	wwd_state_type state_reg;
	wwd_state_type state_next;
	logic hb_deb;
	logic mode_deb;
	logic wake_deb;
	logic supply_deb;
	logic hb_prev_reg;
	logic wake_prev_reg;
	logic hb_rise;
	logic wake_edge;
	logic trg_err;
	logic tmo;
	logic state_change;
	logic monitoring;
	logic short_win;
	logic long_win;
	logic [TIMER_W-1:0] timer_count;
	logic [TIMER_W-1:0] limit_sel;
	logic [TIMER_W-1:0] hb_low_reg;
	logic [1:0] good_cnt_reg;
	logic [1:0] good_cnt_next;

	// ==========================================
	// input conditioning
	// trigger and mode idle high (pulled up), wake-up idles low
	wwd_debounce #(.STABLE(DEBOUNCE_CYC), .INIT(1'b1)) u_deb_hb (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.raw_in(heartbeat_input),
		.level_out(hb_deb)
	);

	wwd_debounce #(.STABLE(DEBOUNCE_CYC), .INIT(1'b1)) u_deb_mode (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.raw_in(mode_input),
		.level_out(mode_deb)
	);

	wwd_debounce #(.STABLE(DEBOUNCE_CYC), .INIT(1'b0)) u_deb_wake (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.raw_in(wakeup_input),
		.level_out(wake_deb)
	);

	// supply monitor level is only synchronised, not filtered
	wwd_debounce #(.STABLE(1), .INIT(1'b0)) u_sync_supply (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.raw_in(supply_ok_input),
		.level_out(supply_deb)
	);

	// ==========================================
	// edge detection
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hb_prev_reg <= 1'b1;
			wake_prev_reg <= 1'b0;
		end else begin
			hb_prev_reg <= hb_deb;
			wake_prev_reg <= wake_deb;
		end
	end

	assign hb_rise = hb_deb & ~hb_prev_reg;
	assign wake_edge = wake_deb ^ wake_prev_reg;

	assign short_win = (state_reg == ST_SHORT_DIS) || (state_reg == ST_SHORT_EN);
	assign long_win = (state_reg == ST_LONG_DIS) || (state_reg == ST_LONG_EN);
	assign monitoring = short_win || long_win;

	// ==========================================
	// trigger low-time supervision
	// counted only while monitoring, so a low trigger during switch-over is harmless
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hb_low_reg <= '0;
		end else if (hb_deb || !monitoring) begin
			hb_low_reg <= '0;
		end else if (hb_low_reg != {TIMER_W{1'b1}}) begin
			hb_low_reg <= hb_low_reg + 1'b1;
		end
	end

	assign trg_err = (hb_low_reg >= TIMER_W'(TRG_LOW_MAX_CYC));

	// ==========================================
	// interval timer
	// held clear while supply is low, so the power-on hold counts from recovery
	assign state_change = (state_next != state_reg) || !supply_deb;

	wwd_interval_timer #(.WIDTH(TIMER_W)) u_timer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.restart(state_change),
		.count(timer_count)
	);

	// period of the current state, minus one since the count starts at zero
	always_comb begin
		unique case (state_reg)
			ST_POR: limit_sel = TIMER_W'(POR_HOLD_CYC - 1);
			ST_SWITCH: limit_sel = TIMER_W'(SWITCH_TMO_CYC - 1);
			ST_SHORT_DIS: limit_sel = TIMER_W'(SHORT_DIS_CYC - 1);
			ST_SHORT_EN: limit_sel = TIMER_W'(SHORT_EN_CYC - 1);
			ST_LONG_DIS: limit_sel = TIMER_W'(LONG_DIS_CYC - 1);
			ST_LONG_EN: limit_sel = TIMER_W'(LONG_EN_CYC - 1);
			ST_RST_PULSE: limit_sel = TIMER_W'(RST_PULSE_CYC - 1);
			default: limit_sel = '0;
		endcase
	end

	assign tmo = (timer_count >= limit_sel);

	// ==========================================
	// supervisor state machine
	// a pin event one cycle before a timeout cannot double-step: the timer clears with the change
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_POR: begin
				if (tmo) state_next = ST_SWITCH;
			end
			ST_SWITCH: begin
				if (!mode_deb) state_next = ST_SHORT_DIS;
				else if (tmo) state_next = ST_RST_PULSE;
			end
			ST_SHORT_DIS: begin
				if (hb_rise || trg_err) state_next = ST_RST_PULSE;
				else if (mode_deb) state_next = ST_LONG_DIS;
				else if (tmo) state_next = ST_SHORT_EN;
			end
			ST_SHORT_EN: begin
				if (trg_err) state_next = ST_RST_PULSE;
				else if (hb_rise) state_next = ST_SHORT_DIS;
				else if (mode_deb) state_next = ST_LONG_DIS;
				else if (tmo) state_next = ST_RST_PULSE;
			end
			ST_LONG_DIS: begin
				if (wake_edge || hb_rise || trg_err) state_next = ST_RST_PULSE;
				else if (!mode_deb) state_next = ST_SHORT_DIS;
				else if (tmo) state_next = ST_LONG_EN;
			end
			ST_LONG_EN: begin
				if (wake_edge || trg_err) state_next = ST_RST_PULSE;
				else if (hb_rise) state_next = ST_LONG_DIS;
				else if (!mode_deb) state_next = ST_SHORT_DIS;
				else if (tmo) state_next = ST_RST_PULSE;
			end
			ST_RST_PULSE: begin
				if (tmo) state_next = ST_SWITCH;
			end
			default: state_next = ST_POR;
		endcase
		if (!supply_deb) state_next = ST_POR;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_POR;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================
	// correct-trigger count and permit output
	always_comb begin
		good_cnt_next = good_cnt_reg;
		if (state_next != ST_SHORT_DIS && state_next != ST_SHORT_EN) begin
			good_cnt_next = 2'h0;
		end else if (state_reg == ST_SHORT_EN && state_next == ST_SHORT_DIS &&
			good_cnt_reg != `WWD_GOOD_TARGET) begin
			good_cnt_next = good_cnt_reg + 2'h1;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			good_cnt_reg <= 2'h0;
			peripheral_permit_output <= 1'b0;
		end else begin
			good_cnt_reg <= good_cnt_next;
			peripheral_permit_output <= (good_cnt_next == `WWD_GOOD_TARGET);
		end
	end

	// ==========================================
	// open-drain reset pin, active low: only ever pulls down
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reset_pin_out <= 1'b0;
			reset_pin_oe <= 1'b1;
		end else begin
			reset_pin_out <= 1'b0;
			reset_pin_oe <= (state_next == ST_POR) || (state_next == ST_RST_PULSE);
		end
	end

	// ==========================================
	// assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_wake_long_reset: assert property (long_win && wake_edge && supply_deb |=>
		state_reg == ST_RST_PULSE && reset_pin_oe)
		else $error("wake-up edge in long window gave no reset");

	a_mode_high_long: assert property (state_reg == ST_SHORT_DIS && mode_deb && !hb_rise &&
		!trg_err && supply_deb |=> state_reg == ST_LONG_DIS)
		else $error("mode high did not enter long window");

	a_mode_low_short: assert property (long_win && !mode_deb && !wake_edge && !hb_rise &&
		!trg_err && supply_deb |=> state_reg == ST_SHORT_DIS)
		else $error("mode low did not return to short window");

	a_permit_three: assert property ($rose(peripheral_permit_output) |->
		good_cnt_reg == 2'h3 && $past(state_reg) == ST_SHORT_EN && state_reg == ST_SHORT_DIS)
		else $error("permit rose without third correct trigger");

	a_error_drops_permit: assert property (state_reg == ST_RST_PULSE |->
		!peripheral_permit_output && good_cnt_reg == 2'h0)
		else $error("permit or count survived a reset pulse");

	a_supply_drop: assert property (!supply_deb |=> state_reg == ST_POR && reset_pin_oe &&
		!peripheral_permit_output)
		else $error("supply drop did not force initial state");

	a_por_release: assert property (state_reg == ST_POR && supply_deb &&
		timer_count == TIMER_W'(POR_HOLD_CYC - 1) |=> state_reg == ST_SWITCH && !reset_pin_oe)
		else $error("power-on hold not released on time");

	a_switch_timeout: assert property (state_reg == ST_SWITCH && mode_deb && supply_deb &&
		timer_count == TIMER_W'(SWITCH_TMO_CYC - 1) |=> state_reg == ST_RST_PULSE ##1 timer_count == 1)
		else $error("switch-over timeout gave no reset pulse");

	a_pulse_to_switch: assert property (state_reg == ST_RST_PULSE && tmo && supply_deb |=>
		state_reg == ST_SWITCH && !reset_pin_oe)
		else $error("reset pulse did not reenter switch-over");

	a_early_trigger: assert property (state_reg == ST_SHORT_DIS && hb_rise && supply_deb |=>
		state_reg == ST_RST_PULSE)
		else $error("trigger in disable period not punished");

	a_missing_trigger: assert property (state_reg == ST_SHORT_EN && tmo && !hb_rise && !mode_deb &&
		supply_deb |=> state_reg == ST_RST_PULSE)
		else $error("empty enable period gave no reset");

	a_long_no_permit: assert property (long_win |-> !peripheral_permit_output)
		else $error("permit high in long window");

	a_timer_restart: assert property (state_reg != $past(state_reg) |-> timer_count == '0)
		else $error("timer not restarted on state change");

	c_permit_on: cover property ($rose(peripheral_permit_output));
	c_long_entry: cover property (state_reg == ST_SHORT_EN ##1 state_reg == ST_LONG_DIS);
	c_wake_reset: cover property (state_reg == ST_LONG_EN ##1 state_reg == ST_RST_PULSE);
	c_switch_tmo: cover property (state_reg == ST_SWITCH ##1 state_reg == ST_RST_PULSE);

endmodule // wwd_top

// ==== rtl/wwd_defines.svh ====
/*
 * default cycle counts for the window watchdog.
 * assumes a 100 MHz core_clk; every period but WWD_CLK_PERIOD_NS is in clock cycles.
 */
`ifndef WWD_DEFINES_SVH
`define WWD_DEFINES_SVH

// ==========================================
// clock
`define WWD_CLK_PERIOD_NS 10

// ==========================================
// periods, in cycles
`define WWD_POR_HOLD_CYC 2000
`define WWD_SWITCH_TMO_CYC 5000
`define WWD_SHORT_DIS_CYC 400
`define WWD_SHORT_EN_CYC 400
`define WWD_LONG_DIS_CYC 40000
`define WWD_LONG_EN_CYC 20000
`define WWD_TRG_LOW_MAX_CYC 100
`define WWD_RST_PULSE_CYC 200
`define WWD_DEBOUNCE_CYC 3

// ==========================================
// widths and the correct-trigger target
`define WWD_TIMER_W 24
`define WWD_GOOD_TARGET 2'h3

`endif

// ==== rtl/wwd_pkg.sv ====
/*
 * types shared by the window watchdog files.
 * assumes nothing of its surroundings.
 */
package wwd_pkg;

	// ==========================================
	// supervisor states
	typedef enum logic [2:0] {
		ST_POR,
		ST_SWITCH,
		ST_SHORT_DIS,
		ST_SHORT_EN,
		ST_LONG_DIS,
		ST_LONG_EN,
		ST_RST_PULSE
	} wwd_state_type;

endpackage

// ==== rtl/wwd_debounce.sv ====
/*
 * two-flop synchroniser followed by a stability filter.
 * assumes raw_in is asynchronous to core_clk.
 */
`timescale 1ns/100ps

module wwd_debounce #(
	parameter int unsigned STABLE = 3,
	parameter bit INIT = 1'b0
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic raw_in,
	output logic level_out
);

	localparam int CW = $clog2(STABLE + 1);

	if (STABLE < 1) begin : g_bad_stable
		$error("wwd_debounce: STABLE must be at least 1");
	end

	logic meta_reg;
	logic sync_reg;
	logic [CW-1:0] cnt_reg;

	// ==========================================
	// synchroniser
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_reg <= INIT;
			sync_reg <= INIT;
		end else begin
			meta_reg <= raw_in;
			sync_reg <= meta_reg;
		end
	end

	// ==========================================
	// filter: a new level must hold STABLE cycles
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_reg <= '0;
			level_out <= INIT;
		end else if (sync_reg == level_out) begin
			cnt_reg <= '0;
		end else if (cnt_reg == CW'(STABLE - 1)) begin
			cnt_reg <= '0;
			level_out <= sync_reg;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

endmodule // wwd_debounce

// ==== rtl/wwd_interval_timer.sv ====
/*
 * interval timer: counts core_clk cycles, cleared by restart.
 * assumes restart comes from logic on the same clock.
 */
`timescale 1ns/100ps

module wwd_interval_timer #(
	parameter int unsigned WIDTH = 24
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic restart,
	output logic [WIDTH-1:0] count
);

	if (WIDTH < 2) begin : g_bad_width
		$error("wwd_interval_timer: WIDTH must be at least 2");
	end

	// ==========================================
	// counter; saturates so a stalled state never wraps
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= '0;
		end else if (restart) begin
			count <= '0;
		end else if (count != {WIDTH{1'b1}}) begin
			count <= count + 1'b1;
		end
	end

endmodule // wwd_interval_timer

// ==== tb/wwd_mcu_model.sv ====
/*
 * behavioural microcontroller that drives the heartbeat and mode pins.
 * assumes the bench calls its tasks and that core_clk is the watchdog clock.
 */
`timescale 1ns/100ps

module wwd_mcu_model (
	input wire logic core_clk,
	output logic heartbeat_input,
	output logic mode_input
);
	// ==========================================
	// pin drivers
	// both pins idle high, as their pull-ups would leave them
	initial begin
		heartbeat_input = 1'b1;
		mode_input = 1'b1;
	end

	// low leaves switch-over and the long window, high asks for it
	task automatic set_mode(input logic v);
		@(negedge core_clk);
		mode_input = v;
	endtask

	// a low pulse closed by a rising edge; a long low_cyc is a deliberate fault
	task automatic beat(input int low_cyc);
		@(negedge core_clk);
		heartbeat_input = 1'b0;
		repeat (low_cyc) @(negedge core_clk);
		heartbeat_input = 1'b1;
	endtask
endmodule // wwd_mcu_model

// ==== tb/wwd_top_tb.sv ====
/*
 * self-checking bench for the window watchdog.
 * assumes wwd_mcu_model drives the controller pins; long counts are shortened.
 */
`timescale 1ns/100ps

`include "wwd_defines.svh"

module wwd_top_tb import wwd_pkg::*;;
	// ==========================================
	// setup
	localparam int SDIS = `WWD_SHORT_DIS_CYC;
	localparam int SEN = `WWD_SHORT_EN_CYC;
	localparam int LDIS = 300;
	localparam int LEN = 200;
	localparam int TMO = 500;
	localparam int POR = `WWD_POR_HOLD_CYC;
	localparam int RP = `WWD_RST_PULSE_CYC;
	localparam int LAT = 6;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic wakeup_input = 1'b0;
	logic supply_ok_input = 1'b1;
	logic heartbeat_input;
	logic mode_input;
	logic reset_pin_out;
	logic reset_pin_oe;
	logic peripheral_permit_output;
	int n_fail = 0;
	int checks_done = 0;

	always #5 core_clk = ~core_clk;

	wwd_top #(.SWITCH_TMO_CYC(TMO), .LONG_DIS_CYC(LDIS), .LONG_EN_CYC(LEN)) wwd_top_i (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.heartbeat_input(heartbeat_input),
		.mode_input(mode_input),
		.wakeup_input(wakeup_input),
		.supply_ok_input(supply_ok_input),
		.reset_pin_out(reset_pin_out),
		.reset_pin_oe(reset_pin_oe),
		.peripheral_permit_output(peripheral_permit_output)
	);

	wwd_mcu_model wwd_mcu_model_i (
		.core_clk(core_clk),
		.heartbeat_input(heartbeat_input),
		.mode_input(mode_input)
	);

	// ==========================================
	// helpers
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic chk(input string nm, input logic e, input logic s);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %b seen %b", nm, e, s);
		end
	endtask

	task automatic chk_n(input string nm, input int lo, input int hi, input int n);
		checks_done++;
		if (n < lo || n > hi) begin
			n_fail++;
			$display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, n);
		end
	endtask

	// bounded wait; a miss shows up as a count past the window
	task automatic wait_oe(input logic v, input int lim, output int n);
		n = 0;
		while (reset_pin_oe !== v && n < lim) begin
			@(negedge core_clk);
			n++;
		end
	endtask

	task automatic boot;
		int n;
		sys_rst = 1'b1;
		cyc(12);
		sys_rst = 1'b0;
		wait_oe(1'b0, POR + 30, n);
		chk_n("por hold", POR, POR + 8, n);
	endtask

	task automatic go_short;
		wwd_mcu_model_i.set_mode(1'b1);
		boot;
		wwd_mcu_model_i.set_mode(1'b0);
		cyc(LAT);
	endtask

	// rising edge lands mid enable period, clear of both window ends
	task automatic good_beat;
		cyc(SDIS + SEN / 2 - 10 - LAT);
		wwd_mcu_model_i.beat(10);
	endtask

	task automatic done(input string nm);
		$display("test %s done", nm);
	endtask

	// ==========================================
	// scenarios
	task automatic t_permit_early;
		int n;
		go_short;
		for (int i = 1; i <= 3; i++) begin
			good_beat;
			cyc(LAT + 2);
			chk("permit", i == 3, peripheral_permit_output);
			chk("reset", 1'b0, reset_pin_oe);
		end
		cyc(100);
		wwd_mcu_model_i.beat(10);
		cyc(LAT + 2);
		chk("early reset", 1'b1, reset_pin_oe);
		chk("reset data", 1'b0, reset_pin_out);
		chk("permit drop", 1'b0, peripheral_permit_output);
		wait_oe(1'b0, RP + 20, n);
		chk_n("pulse width", RP - 3, RP + 3, n);
		cyc(LAT);
		good_beat;
		cyc(LAT + 2);
		chk("permit recount", 1'b0, peripheral_permit_output);
		done("permit_early");
	endtask

	task automatic t_missing;
		int n;
		go_short;
		wakeup_input = ~wakeup_input;
		cyc(LAT + 2);
		chk("wake short", 1'b0, reset_pin_oe);
		wait_oe(1'b1, SDIS + SEN + 30, n);
		chk_n("no trigger", SDIS + SEN - LAT - 6, SDIS + SEN + 2, n);
		done("missing");
	endtask

	task automatic t_low;
		go_short;
		cyc(SDIS + 50 - LAT);
		wwd_mcu_model_i.beat(130);
		chk("long low", 1'b1, reset_pin_oe);
		done("low");
	endtask

	task automatic t_switch;
		int n;
		wwd_mcu_model_i.set_mode(1'b1);
		boot;
		wait_oe(1'b1, TMO + 30, n);
		chk_n("switch timeout", TMO - 3, TMO + 3, n);
		wait_oe(1'b0, RP + 20, n);
		chk_n("switch pulse", RP - 3, RP + 3, n);
		wait_oe(1'b1, TMO + 30, n);
		chk_n("switch again", TMO - 3, TMO + 3, n);
		done("switch");
	endtask

	task automatic t_long_wake;
		go_short;
		repeat (3) good_beat;
		cyc(LAT + 2);
		chk("permit on", 1'b1, peripheral_permit_output);
		wwd_mcu_model_i.set_mode(1'b1);
		cyc(LAT + 2);
		chk("permit long", 1'b0, peripheral_permit_output);
		cyc(LDIS + LEN / 2);
		chk("long quiet", 1'b0, reset_pin_oe);
		wakeup_input = ~wakeup_input;
		cyc(LAT + 2);
		chk("wake reset", 1'b1, reset_pin_oe);
		done("long_wake");
	endtask

	task automatic t_back;
		go_short;
		wwd_mcu_model_i.set_mode(1'b1);
		cyc(LDIS + LEN / 2 - 18);
		wwd_mcu_model_i.beat(10);
		cyc(150);
		chk("long trigger", 1'b0, reset_pin_oe);
		wwd_mcu_model_i.set_mode(1'b0);
		cyc(LAT);
		good_beat;
		cyc(LAT + 2);
		chk("back short", 1'b0, reset_pin_oe);
		done("back");
	endtask

	task automatic t_supply;
		int n;
		go_short;
		repeat (3) good_beat;
		cyc(LAT + 2);
		chk("permit before drop", 1'b1, peripheral_permit_output);
		supply_ok_input = 1'b0;
		cyc(LAT + 2);
		chk("drop reset", 1'b1, reset_pin_oe);
		chk("drop permit", 1'b0, peripheral_permit_output);
		supply_ok_input = 1'b1;
		wait_oe(1'b0, POR + 30, n);
		chk_n("ramp hold", POR, POR + 8, n);
		done("supply");
	endtask

	// ==========================================
	// run control
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		cyc(1);
		t_switch;
		t_permit_early;
		t_missing;
		t_low;
		t_long_wake;
		t_back;
		t_supply;
		close_out;
	end

	// all tests need about 28000 cycles
	initial begin
		repeat (60000) @(posedge core_clk);
		n_fail++;
		close_out;
	end
endmodule // wwd_top_tb
